/* hw/sdc_ctrl.sv */
/*
 * Dead-time compensation controller for two synchronous-rectifier gates.
 * It generates the gate commands, measures body-diode conduction reported
 * by the driver after each turn-off, and moves the next turn-off edge.
 * Assumes the driver's conduction flags are asynchronous pins (active low
 * while conducting) and software programs it over APB on pclk.
 */
module sdc_ctrl
	import sdc_pkg::*;
#(
	parameter int N_CH = sdc_pkg::NUM_CH
)(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic [N_CH-1:0]   conduction_input,
	output logic [N_CH-1:0]        sr_gate,
	output logic                   turn_on_opt_en,
	output logic                   irq
);
	import sdc_pkg::*;

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	sdc_cfg_t          cfg_ff;
	logic [STAT_W-1:0] status_ff;
	logic [STAT_W-1:0] mask_ff;
	logic              pready_ff;
	logic [31:0]       prdata_ff;
	logic              pslverr_ff;
	logic              acc_en;
	logic              rd_stat;
	logic              mapped;
	logic [31:0]       rd_mux;
	logic [STAT_W-1:0] ev_set;
	logic [CNT_W-1:0]  cnt_q [N_CH];
	logic [15:0]       acc_q [N_CH];

	// A setup cycle loads the read data, so the first access cycle
	// answers from flip-flops with one wait state never needed.
	assign acc_en  = psel & penable & pready_ff;
	assign rd_stat = acc_en & ~pwrite & (paddr == OFS_STATUS);
	assign pready  = pready_ff;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;

	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			OFS_CTRL:   rd_mux = {28'h0, cfg_ff.ton_opt, cfg_ff.single_ch,
				cfg_ff.auto_mode, cfg_ff.enable};
			OFS_PERIOD: rd_mux = {16'h0000, cfg_ff.period};
			OFS_NOMON:  rd_mux = {16'h0000, cfg_ff.nominal_on};
			OFS_WINDOW: rd_mux = {16'h0000, cfg_ff.window_length,
				cfg_ff.blank};
			OFS_MANUAL: rd_mux = {16'h0000, cfg_ff.manual_offset};
			OFS_CLAMP:  rd_mux = {cfg_ff.clamp_max, cfg_ff.clamp_min};
			OFS_TARGET: rd_mux = {8'h00, cfg_ff.adj_step, cfg_ff.hyst,
				cfg_ff.target};
			OFS_FAULT:  rd_mux = {8'h00, cfg_ff.fault_num,
				cfg_ff.fault_step_size, cfg_ff.fault_thr};
			OFS_COUNT:  rd_mux = {9'h000, cnt_q[1], 9'h000, cnt_q[0]};
			OFS_STATUS: rd_mux = {28'h0, status_ff};
			OFS_MASK:   rd_mux = {28'h0, mask_ff};
			OFS_ACCUM:  rd_mux = {acc_q[1], acc_q[0]};
			default:    mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= psel & ~penable & ~pready_ff;
			if (psel & ~penable)
			begin
				prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr_ff <= ~mapped;
			end
			else
				pslverr_ff <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_ff             <= '0;
			cfg_ff.period      <= RST_PERIOD;
			cfg_ff.nominal_on  <= RST_NOMON;
			cfg_ff.clamp_min   <= RST_CLMIN;
			cfg_ff.clamp_max   <= RST_CLMAX;
			mask_ff            <= '0;
		end
		else if (acc_en && pwrite)
		begin
			case (paddr)
				OFS_CTRL:
				begin
					cfg_ff.enable    <= pwdata[CTRL_EN];
					cfg_ff.auto_mode <= pwdata[CTRL_AUTO];
					cfg_ff.single_ch <= pwdata[CTRL_SINGLE];
					cfg_ff.ton_opt   <= pwdata[CTRL_TONOPT];
				end
				OFS_PERIOD: cfg_ff.period <= pwdata[15:0];
				OFS_NOMON:  cfg_ff.nominal_on <= pwdata[15:0];
				OFS_WINDOW:
				begin
					cfg_ff.blank         <= pwdata[7:0];
					cfg_ff.window_length <= pwdata[B2_LSB +: 8];
				end
				OFS_MANUAL: cfg_ff.manual_offset <= pwdata[15:0];
				OFS_CLAMP:
				begin
					cfg_ff.clamp_min <= pwdata[15:0];
					cfg_ff.clamp_max <= pwdata[HI_LSB +: 16];
				end
				OFS_TARGET:
				begin
					cfg_ff.target   <= pwdata[7:0];
					cfg_ff.hyst     <= pwdata[B2_LSB +: 8];
					cfg_ff.adj_step <= pwdata[B3_LSB +: 8];
				end
				OFS_FAULT:
				begin
					cfg_ff.fault_thr       <= pwdata[7:0];
					cfg_ff.fault_step_size <= pwdata[B2_LSB +: 8];
					cfg_ff.fault_num       <= pwdata[B3_LSB +: 8];
				end
				OFS_MASK: mask_ff <= pwdata[STAT_W-1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------------
	// Only the bits already reported in the setup cycle are cleared, so an
	// event that lands between setup and access is not lost.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_ff <= '0;
		else
			status_ff <= (rd_stat ? status_ff & ~prdata_ff[STAT_W-1:0]
				: status_ff) | ev_set;
	end

	assign irq            = |(status_ff & mask_ff);
	assign turn_on_opt_en = cfg_ff.ton_opt;

	// ------------------------------------------------------------------
	// Switching period
	// ------------------------------------------------------------------
	logic [15:0] phase_ff;
	logic [15:0] half;
	logic [15:0] limit;

	assign half  = cfg_ff.period >> 1;
	assign limit = cfg_ff.single_ch ? cfg_ff.period : half;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_ff <= '0;
		else if (phase_ff + 16'h0001 >= cfg_ff.period)
			phase_ff <= '0;
		else
			phase_ff <= phase_ff + 16'h0001;
	end

	// ------------------------------------------------------------------
	// Per-channel gate, window and accumulator
	// ------------------------------------------------------------------
	for (genvar g = 0; g < N_CH; g++)
	begin : g_ch
		logic [1:0]       sync_ff;
		logic             gate_ff;
		sdc_win_t         st_ff;
		logic [7:0]       tim_ff;
		logic [CNT_W-1:0] meas_ff;
		logic [CNT_W-1:0] cnt_ff;
		logic [7:0]       fcnt_ff;
		logic signed [15:0] acc_ff;
		logic signed [15:0] nxt_acc;
		logic signed [17:0] edge_raw;
		logic [15:0]      edge_pos;
		logic [15:0]      start;
		logic [15:0]      rel;
		logic             active;
		logic             nxt_gate;
		logic             is_fault;
		logic             do_step;
		logic [8:0]       hi_band;
		logic [8:0]       lo_band;

		// Flag arrives from the driver's comparator off-chip.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				sync_ff <= 2'b11;
			else
				sync_ff <= {sync_ff[0], conduction_input[g]};
		end

		assign start  = (g == 0) ? 16'h0000 : half;
		assign active = (g == 0) || !cfg_ff.single_ch;
		assign rel    = phase_ff - start;

		// Offset is clamped again against the half or whole period.
		always_comb
		begin
			edge_raw = $signed({2'b00, cfg_ff.nominal_on})
				+ (cfg_ff.enable ? 18'(acc_ff) : 18'sh0);
			if (edge_raw < 0)
				edge_pos = 16'h0000;
			else if (edge_raw > $signed({2'b00, limit}))
				edge_pos = limit;
			else
				edge_pos = edge_raw[15:0];
			nxt_gate = active && phase_ff >= start && rel < limit
				&& rel < edge_pos;
		end

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				gate_ff <= 1'b0;
			else
				gate_ff <= nxt_gate;
		end
		assign sr_gate[g] = gate_ff;

		// Window opens on the gate command falling edge.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				st_ff   <= WIN_IDLE;
				tim_ff  <= '0;
				meas_ff <= '0;
			end
			else
			begin
				case (st_ff)
					WIN_IDLE:
						if (gate_ff && !nxt_gate && cfg_ff.enable)
						begin
							st_ff   <= WIN_BLANK;
							tim_ff  <= '0;
							meas_ff <= '0;
						end
					WIN_BLANK:
						if (tim_ff >= cfg_ff.blank)
						begin
							st_ff  <= WIN_MEAS;
							tim_ff <= '0;
						end
						else
							tim_ff <= tim_ff + 8'h01;
					WIN_MEAS:
					begin
						// TICKS_PER_COUNT counts per conducting clock, saturating.
						if (!sync_ff[1] && meas_ff != CNT_MAX)
							meas_ff <= meas_ff + 7'(TICKS_PER_COUNT);
						if (tim_ff + 8'h01 >= cfg_ff.window_length)
							st_ff <= WIN_UPDATE;
						tim_ff <= tim_ff + 8'h01;
					end
					WIN_UPDATE: st_ff <= WIN_IDLE;
					default:    st_ff <= WIN_IDLE;
				endcase
			end
		end

		assign is_fault = {1'b0, meas_ff} < cfg_ff.fault_thr;
		assign do_step  = is_fault
			&& (fcnt_ff + 8'h01 >= cfg_ff.fault_num);
		assign hi_band  = 9'(cfg_ff.target) + 9'(cfg_ff.hyst);
		assign lo_band  = 9'(cfg_ff.target) - 9'(cfg_ff.hyst);

		always_comb
		begin
			nxt_acc = acc_ff;
			if (!cfg_ff.auto_mode)
				nxt_acc = $signed(cfg_ff.manual_offset);
			else if (do_step)
				nxt_acc = acc_ff
					- $signed({8'h00, cfg_ff.fault_step_size});
			else if (9'(meas_ff) > hi_band)
				nxt_acc = acc_ff + $signed({8'h00, cfg_ff.adj_step});
			else if ($signed({1'b0, 9'(meas_ff)}) < $signed({1'b0, lo_band})
				&& cfg_ff.target >= cfg_ff.hyst)
				nxt_acc = acc_ff - $signed({8'h00, cfg_ff.adj_step});
			// Inside the band the edge is left alone.
			if (nxt_acc > $signed(cfg_ff.clamp_max))
				nxt_acc = $signed(cfg_ff.clamp_max);
			if (nxt_acc < $signed(cfg_ff.clamp_min))
				nxt_acc = $signed(cfg_ff.clamp_min);
		end

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				acc_ff  <= '0;
				cnt_ff  <= '0;
				fcnt_ff <= '0;
			end
			else if (!cfg_ff.enable)
			begin
				acc_ff  <= '0;
				fcnt_ff <= '0;
			end
			else if (st_ff == WIN_UPDATE)
			begin
				cnt_ff <= meas_ff;
				acc_ff <= nxt_acc;
				if (!is_fault || do_step)
					fcnt_ff <= '0;
				else
					fcnt_ff <= fcnt_ff + 8'h01;
			end
		end

		assign cnt_q[g] = cnt_ff;
		assign acc_q[g] = acc_ff;
		assign ev_set[ST_FAULT + g] = (st_ff == WIN_UPDATE) && is_fault
			&& cfg_ff.enable;
		assign ev_set[ST_STEP + g]  = (st_ff == WIN_UPDATE) && do_step
			&& cfg_ff.enable && cfg_ff.auto_mode;
	end

endmodule

/* pkg/sdc_pkg.sv */
/*
 * Shared constants and types for the synchronous-rectifier dead-time
 * compensation controller: register offsets, field positions, reset values
 * and the window state encoding.
 * Assumes a 32-bit APB register port and one system clock.
 */
package sdc_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 100;
	localparam int TIMER_RES_NS    = 4;
	// The capture timer cannot tick faster than the clock; one count is
	// one clock at this rate, so resolution is coarser than the target.
	localparam int TICKS_PER_COUNT = (TIMER_RES_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_NOMON  = 8'h08;
	localparam logic [7:0] OFS_WINDOW = 8'h0C;
	localparam logic [7:0] OFS_MANUAL = 8'h10;
	localparam logic [7:0] OFS_CLAMP  = 8'h14;
	localparam logic [7:0] OFS_TARGET = 8'h18;
	localparam logic [7:0] OFS_FAULT  = 8'h1C;
	localparam logic [7:0] OFS_COUNT  = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_MASK   = 8'h28;
	localparam logic [7:0] OFS_ACCUM  = 8'h2C;

	// ------------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------------
	localparam int CTRL_EN     = 0;
	localparam int CTRL_AUTO   = 1;
	localparam int CTRL_SINGLE = 2;
	localparam int CTRL_TONOPT = 3;
	localparam int HI_LSB      = 16;
	localparam int B2_LSB      = 8;
	localparam int B3_LSB      = 16;
	localparam int CNT_W       = 7;
	localparam int NUM_CH      = 2;
	localparam int STAT_W      = 4;
	localparam int ST_FAULT    = 0;
	localparam int ST_STEP     = 2;

	localparam logic [CNT_W-1:0] CNT_MAX = 7'h7F;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] RST_PERIOD = 16'h0064;
	localparam logic [15:0] RST_NOMON  = 16'h0028;
	localparam logic [15:0] RST_CLMIN  = 16'hFFE0;
	localparam logic [15:0] RST_CLMAX  = 16'h0008;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        enable;
		logic        auto_mode;
		logic        single_ch;
		logic        ton_opt;
		logic [15:0] period;
		logic [15:0] nominal_on;
		logic [7:0]  blank;
		logic [7:0]  window_length;
		logic [15:0] manual_offset;
		logic [15:0] clamp_min;
		logic [15:0] clamp_max;
		logic [7:0]  target;
		logic [7:0]  hyst;
		logic [7:0]  adj_step;
		logic [7:0]  fault_thr;
		logic [7:0]  fault_step_size;
		logic [7:0]  fault_num;
	} sdc_cfg_t;

	typedef enum logic [1:0] {
		WIN_IDLE,
		WIN_BLANK,
		WIN_MEAS,
		WIN_UPDATE
	} sdc_win_t;

endpackage

/* tb/sdc_ctrl_monitor.sv */
/*
 * Checker for the compensation controller's register port and gates.
 * Assumes it is bound to sdc_ctrl and sees only that module's ports.
 */
module sdc_ctrl_monitor
	import sdc_pkg::*;
#(
	parameter int N_CH = 2
)(
	input wire logic            pclk,
	input wire logic            presetn,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [7:0]      paddr,
	input wire logic [31:0]     pwdata,
	input wire logic            pready,
	input wire logic [31:0]     prdata,
	input wire logic            pslverr,
	input wire logic [N_CH-1:0] sr_gate,
	input wire logic            turn_on_opt_en
);
	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	ready_setup_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("answer outside access phase");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without answer");
	err_unmapped_a: assert property (psel && !penable &&
		(paddr > OFS_ACCUM || paddr[1:0] != 2'h0)
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	map_ok_a: assert property (psel && !penable &&
		paddr <= OFS_ACCUM && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped access refused");
	wr_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("write answer carries data");
	opt_follow_a: assert property (psel && penable && pready && pwrite &&
		paddr == OFS_CTRL |=> turn_on_opt_en == $past(pwdata[CTRL_TONOPT]))
		else $error("turn-on option not taken");
	gate_excl_a: assert property ($onehot0(sr_gate))
		else $error("both gates on");
endmodule

bind sdc_ctrl sdc_ctrl_monitor #(.N_CH(N_CH)) sdc_ctrl_monitor_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .sr_gate(sr_gate),
	.turn_on_opt_en(turn_on_opt_en));

/* tb/sdc_drv_model.sv */
/*
 * Behavioural gate driver with body-diode sensing for two channels.
 * Assumes the gate commands are sampled on pclk; the diode conducts for
 * cond_len clocks starting two clocks after each gate fall.
 */
module sdc_drv_model (
	input  wire logic       pclk,
	input  wire logic [1:0] gate,
	input  wire logic [7:0] cond_len,
	output logic      [1:0] conduction_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] gate_q = 2'h0;
	int         cnt [2] = '{999, 999};

	always @(posedge pclk)
	begin
		gate_q <= gate;
		for (int c = 0; c < 2; c++)
		begin
			if (gate_q[c] && !gate[c])
				cnt[c] <= 0;
			else if (cnt[c] < 999)
				cnt[c] <= cnt[c] + 1;
		end
	end

	// The comparator output is always driven, so it is high, not floating,
	// while the diode is off.
	always_comb
	begin
		for (int c = 0; c < 2; c++)
			conduction_flag[c] = !(cnt[c] >= 2 && cnt[c] < 2 + cond_len);
	end
endmodule

/* tb/sdc_ctrl_tb.sv */
/*
 * Self-checking bench for the dead-time compensation controller.
 * Assumes the driver model and the bound checker are compiled alongside.
 */
module sdc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sdc_pkg::*;

	typedef struct packed {
		logic [3:0]  ctrl;
		logic [15:0] nom;
		logic [15:0] off;
		logic [15:0] win;
		logic [7:0]  cond;
		logic [7:0]  w;
		logic [15:0] acc;
		logic [7:0]  cnt;
	} sdc_row_t;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0]  cond_len = 8'h00;
	logic [1:0]  conduction_input;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [1:0]  sr_gate;
	logic        turn_on_opt_en;
	logic        irq;
	logic [31:0] rd;
	logic [31:0] a1;
	logic        er;
	int          failures = 0;
	int          total_checks = 0;
	int          w;
	sdc_row_t    r;
	sdc_row_t    rows [7] = '{
		'{4'h0, 16'h0028, 16'h0005, 16'h1E00, 8'h06, 8'h28, 16'h0000, 8'h00},
		'{4'h1, 16'h0028, 16'h0000, 16'h1E00, 8'h06, 8'h28, 16'h0000, 8'h06},
		'{4'h9, 16'h0028, 16'h0005, 16'h1E00, 8'h09, 8'h2D, 16'h0005, 8'h09},
		'{4'h1, 16'h0028, 16'h0014, 16'h1E00, 8'h03, 8'h30, 16'h0008, 8'h03},
		'{4'h1, 16'h0028, 16'hFFD8, 16'h1E00, 8'h0C, 8'h08, 16'hFFE0, 8'h0C},
		'{4'h1, 16'h005A, 16'h0000, 16'h1E00, 8'h04, 8'h32, 16'h0000, 8'h04},
		'{4'h1, 16'h0028, 16'h0000, 16'h1E14, 8'h06, 8'h28, 16'h0000, 8'h00}};

	initial
	begin
		forever #50 pclk = ~pclk;
	end

	sdc_ctrl sdc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.conduction_input(conduction_input), .sr_gate(sr_gate),
		.turn_on_opt_en(turn_on_opt_en), .irq(irq));

	sdc_drv_model sdc_drv_model_i (.pclk(pclk), .gate(sr_gate),
		.cond_len(cond_len), .conduction_flag(conduction_input));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic summarize();
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic hang();
		failures++;
		summarize();
	endtask

	// The request stays up until pready is seen high, for at most 20 access cycles.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic wgate(input logic v);
		int n;
		n = 0;
		while (sr_gate[0] !== v && n < 999)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 999)
			hang();
	endtask

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge pclk);
		chk({29'h0, sr_gate, irq}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(OFS_PERIOD, 32'h64);
		rdc(OFS_NOMON, 32'h28);
		rdc(OFS_CLAMP, 32'h0008FFE0);
		rdc(8'h30, 32'h0);
		chk({31'h0, er}, 32'h1);
		foreach (rows[i])
		begin
			r = rows[i];
			apb(1'b1, OFS_CTRL, {28'h0, r.ctrl});
			apb(1'b1, OFS_NOMON, {16'h0, r.nom});
			apb(1'b1, OFS_MANUAL, {16'h0, r.off});
			apb(1'b1, OFS_WINDOW, {16'h0, r.win});
			cond_len <= r.cond;
			repeat (300) @(posedge pclk);
			wgate(1'b0);
			wgate(1'b1);
			w = 0;
			while (sr_gate[0] === 1'b1 && w < 999)
			begin
				@(posedge pclk);
				w++;
			end
			chk(32'(w), {24'h0, r.w});
			apb(1'b0, OFS_ACCUM, 32'h0);
			chk({16'h0, rd[15:0]}, {16'h0, r.acc});
			apb(1'b0, OFS_COUNT, 32'h0);
			chk({25'h0, rd[6:0]}, {25'h0, r.cnt[6:0]});
			chk({25'h0, rd[22:16]}, {25'h0, r.cnt[6:0]});
			chk({31'h0, turn_on_opt_en}, {31'h0, r.ctrl[3]});
		end
		cond_len <= 8'h14;
		apb(1'b1, OFS_NOMON, 32'h28);
		apb(1'b1, OFS_WINDOW, 32'h1E00);
		apb(1'b1, OFS_TARGET, 32'h0001020A);
		apb(1'b1, OFS_FAULT, 32'h00C80403);
		apb(1'b1, OFS_CTRL, 32'h3);
		repeat (2000) @(posedge pclk);
		rdc(OFS_ACCUM, 32'h00080008);
		cond_len <= 8'h0B;
		repeat (500) @(posedge pclk);
		rdc(OFS_ACCUM, 32'h00080008);
		rdc(OFS_STATUS, 32'h0);
		cond_len <= 8'h01;
		repeat (500) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rdc(OFS_STATUS, 32'h3);
		apb(1'b1, OFS_MASK, 32'h1);
		repeat (100) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, OFS_FAULT, 32'h00010403);
		apb(1'b1, OFS_TARGET, 32'h00000302);
		wgate(1'b0);
		wgate(1'b1);
		apb(1'b0, OFS_ACCUM, 32'h0);
		a1 = rd;
		wgate(1'b0);
		wgate(1'b1);
		apb(1'b0, OFS_ACCUM, 32'h0);
		chk({16'h0, rd[15:0]}, {16'h0, a1[15:0] - 16'h0004});
		rdc(OFS_STATUS, 32'hF);
		apb(1'b1, OFS_CTRL, 32'h5);
		apb(1'b1, OFS_MANUAL, 32'h0);
		apb(1'b1, OFS_PERIOD, 32'h190);
		apb(1'b1, OFS_WINDOW, 32'hC800);
		cond_len <= 8'h96;
		repeat (1500) @(posedge pclk);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk({25'h0, rd[6:0]}, {25'h0, CNT_MAX});
		chk({31'h0, sr_gate[1]}, 32'h0);
		summarize();
	end
endmodule
